// [bench/pirqf_src_model.sv]
// behavioural model of the peripherals that raise flag conditions
`timescale 1ns/1ps
module pirqf_src_model (
  // clock
  input  wire logic       aclk,
  // commands from the bench
  input  wire logic [7:0] fire,
  input  wire logic       rx_set,
  input  wire logic       tx_set,
  // towards the flag bank
  output logic [7:0]      evt,
  output logic            rx_lvl,
  output logic            tx_lvl
);
  // launched on the clock so pulses last exactly one cycle
  always_ff @(posedge aclk) begin
    evt    <= fire;
    rx_lvl <= rx_set;
    tx_lvl <= tx_set;
  end
endmodule

// [bench/pirqf_top_sva.sv]
// checker of the flag bank register port, bound to the top module
`timescale 1ns/1ps
module pirqf_top_sva
  import pirqf_pkg::*;
(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [AXI_DW-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // requests
  input wire logic              periph_irq_req,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge, as the bench offers them
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_b_lat;
    s_wr_taken |-> !s_axi_bvalid [*2] ##1 s_axi_bvalid;
  endproperty
  property p_r_lat;
    s_rd_taken |-> !s_axi_rvalid [*2] ##1 s_axi_rvalid;
  endproperty
  property p_aw_back;
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
  endproperty
  property p_ar_back;
    s_axi_rvalid && s_axi_rready |=> s_axi_arready;
  endproperty
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  property p_rst_zero;
    $rose(aresetn) |-> !periph_irq_req && !irq;
  endproperty

  a_b_lat: assert property (p_b_lat) else $error("write response timing wrong");
  a_r_lat: assert property (p_r_lat) else $error("read data timing wrong");
  a_aw_back: assert property (p_aw_back) else $error("write ready not restored");
  a_ar_back: assert property (p_ar_back) else $error("read ready not restored");
  a_b_busy: assert property (p_b_busy) else $error("write taken while response open");
  a_r_busy: assert property (p_r_busy) else $error("read taken while data open");
  a_r_upper: assert property (p_r_upper) else $error("upper read bits not zero");
  a_rst_zero: assert property (p_rst_zero) else $error("request after reset");
endmodule

bind pirqf_top pirqf_top_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .periph_irq_req, .irq);

// [bench/tb.sv]
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ps
module tb;
  import pirqf_pkg::*;
  logic              aclk    = 1'b0;
  logic              aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr  = '0;
  logic [AXI_AW-1:0] araddr  = '0;
  logic [AXI_DW-1:0] wdata   = '0;
  logic              awvalid = 1'b0;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  logic [7:0]        fire    = 8'h00;
  logic              rx_set  = 1'b0;
  logic              tx_set  = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, rx_lvl, tx_lvl, req, glob_en, irq;
  logic [1:0]        bresp, rresp;
  logic [AXI_DW-1:0] rdata;
  logic [7:0]        evt;
  int                bits[6] = '{7, 6, 3, 2, 1, 0};
  int                bad_count = 0;
  int                n_tests = 0;

  // 50 MHz
  always #10 aclk = ~aclk;

  pirqf_src_model i_src (.aclk(aclk), .fire(fire), .rx_set(rx_set), .tx_set(tx_set),
    .evt(evt), .rx_lvl(rx_lvl), .tx_lvl(tx_lvl));

  pirqf_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_one_gate_evt(evt[7]),
    .converter_done_evt(evt[6]), .sync_serial_evt(evt[3]), .capcomp_one_evt(evt[2]),
    .timer_two_match_evt(evt[1]), .timer_one_overflow_evt(evt[0]),
    .uart_rx_pending(rx_lvl), .uart_tx_pending(tx_lvl), .periph_irq_req(req),
    .global_irq_enable(glob_en), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      bad_count++;
      wrap_up();
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      bad_count++;
      wrap_up();
    end
    @(posedge aclk);
  endtask

  // one command cycle, then time for the flag to land
  task automatic pulse(input logic [7:0] m);
    fire <= m;
    @(posedge aclk);
    fire <= 8'h00;
    tick(3);
  endtask

  initial begin
    tick(3);
    aresetn <= 1'b1;
    tick(2);
    // whole map after reset, then an unmapped place
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'hFF, RESP_SLVERR);
    // each writable flag set with all enables off, then cleared by software
    foreach (bits[j]) begin
      pulse(8'h01 << bits[j]);
      rd(OFS_FLAGS, 32'h1 << bits[j], RESP_OKAY);
      chk(req, 1'b0);
      wr(OFS_FLAGS, 32'h0, RESP_OKAY);
      rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    end
    // serial levels show through and ignore software clears
    rx_set <= 1'b1;
    tick(3);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'h20, RESP_OKAY);
    rx_set <= 1'b0;
    tx_set <= 1'b1;
    tick(3);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'h10, RESP_OKAY);
    tx_set <= 1'b0;
    tick(3);
    wr(OFS_FLAGS, 32'hFF, RESP_OKAY);
    rd(OFS_FLAGS, 32'hCF, RESP_OKAY);
    // sticky status, cleared by its read
    rd(OFS_EVSTAT, 32'hFF, RESP_OKAY);
    rd(OFS_EVSTAT, 32'h0, RESP_OKAY);
    // forwarding only with the peripheral enable set
    wr(OFS_ENABLE, 32'hFF, RESP_OKAY);
    tick(2);
    chk(req, 1'b0);
    wr(OFS_ICTRL, 32'hC0, RESP_OKAY);
    tick(2);
    chk(req, 1'b1);
    chk(glob_en, 1'b1);
    rd(OFS_ICTRL, 32'hC0, RESP_OKAY);
    wr(OFS_ICTRL, 32'h80, RESP_OKAY);
    tick(2);
    chk(req, 1'b0);
    // bus interrupt: masked, unmasked, cleared by the status read
    wr(OFS_ICTRL, 32'h40, RESP_OKAY);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    tick(2);
    chk(req, 1'b0);
    pulse(8'h40);
    chk(irq, 1'b0);
    chk(req, 1'b1);
    wr(OFS_EVMASK, 32'h40, RESP_OKAY);
    tick(2);
    chk(irq, 1'b1);
    rd(OFS_EVSTAT, 32'h40, RESP_OKAY);
    tick(1);
    chk(irq, 1'b0);
    wrap_up();
  end
endmodule

// [rtl/pirqf_flag_bank.sv]
// storage of the eight peripheral interrupt flags
`timescale 1ns/1ps
module pirqf_flag_bank
  import pirqf_pkg::*;
(
  // clock and reset
  input wire logic  aclk,
  input wire logic  aresetn,
  // flag traffic
  pirqf_flag_if.bank fl
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // next flag values; a set pulse beats a software clear in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (fl.sw_we) begin
      flags_d = (flags_q & ~FLAG_SW_MASK) | (fl.sw_wdata & FLAG_SW_MASK);
    end
    flags_d = flags_d | (fl.set_pulse & FLAG_SW_MASK);
    // receiver and transmitter flags mirror their source only
    flags_d[BIT_UART_RX] = fl.rx_level;
    flags_d[BIT_UART_TX] = fl.tx_level;
  end

  // registers; every reset clears all flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;
endmodule

// [rtl/pirqf_flag_if.sv]
// link between the register front end and the flag storage
`timescale 1ns/1ps
interface pirqf_flag_if;
  logic [7:0] set_pulse;
  logic       rx_level;
  logic       tx_level;
  logic       sw_we;
  logic [7:0] sw_wdata;
  logic [7:0] flags;

  modport bank (input set_pulse, rx_level, tx_level, sw_we, sw_wdata, output flags);
  modport ctrl (output set_pulse, rx_level, tx_level, sw_we, sw_wdata, input flags);
endinterface

// [rtl/pirqf_pkg.sv]
// constants and register map of the peripheral interrupt flag bank
package pirqf_pkg;
  // bus geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int FLAG_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_ICTRL  = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_EVSTAT = 8'h0C;
  localparam logic [7:0] OFS_EVMASK = 8'h10;

  // flag positions
  localparam int BIT_T1_GATE  = 7;
  localparam int BIT_ADC      = 6;
  localparam int BIT_UART_RX  = 5;
  localparam int BIT_UART_TX  = 4;
  localparam int BIT_SSP      = 3;
  localparam int BIT_CCP1     = 2;
  localparam int BIT_T2_MATCH = 1;
  localparam int BIT_T1_OVF   = 0;

  // interrupt control fields
  localparam int BIT_GLOB_EN   = 7;
  localparam int BIT_PERIPH_EN = 6;

  // bits software may write in the flag register
  localparam logic [7:0] FLAG_SW_MASK = 8'hCF;

  // values after reset
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ICTRL_RST = 8'h00;
  localparam logic [7:0] EN_RST    = 8'h00;
  localparam logic [7:0] EV_RST    = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/pirqf_top.sv]
// peripheral interrupt flag bank with an axi4-lite register port
`timescale 1ns/1ps
module pirqf_top
  import pirqf_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // one-cycle event pulses from the peripherals
  input  wire logic              timer_one_gate_evt,
  input  wire logic              converter_done_evt,
  input  wire logic              sync_serial_evt,
  input  wire logic              capcomp_one_evt,
  input  wire logic              timer_two_match_evt,
  input  wire logic              timer_one_overflow_evt,
  // pending levels from the serial receiver and transmitter
  input  wire logic              uart_rx_pending,
  input  wire logic              uart_tx_pending,
  // towards the processor
  output logic                   periph_irq_req,
  output logic                   global_irq_enable,
  // bus interrupt
  output logic                   irq
);
  pirqf_flag_if fl ();

  // write channel state
  logic              aw_got_q;
  logic              aw_got_d;
  logic              w_got_q;
  logic              w_got_d;
  logic [AXI_AW-1:0] waddr_q;
  logic [AXI_AW-1:0] waddr_d;
  logic [7:0]        wbyte_q;
  logic [7:0]        wbyte_d;
  logic              wlane_q;
  logic              wlane_d;
  logic              awready_q;
  logic              awready_d;
  logic              wready_q;
  logic              wready_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;
  logic              do_wr;

  // read channel state
  logic              ar_got_q;
  logic              ar_got_d;
  logic [AXI_AW-1:0] raddr_q;
  logic [AXI_AW-1:0] raddr_d;
  logic              arready_q;
  logic              arready_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;
  logic              do_rd;

  // software registers and interrupt state
  logic [7:0]        ictrl_q;
  logic [7:0]        ictrl_d;
  logic [7:0]        enable_q;
  logic [7:0]        enable_d;
  logic [7:0]        evstat_q;
  logic [7:0]        evstat_d;
  logic [7:0]        evmask_q;
  logic [7:0]        evmask_d;
  logic [7:0]        flags_prev_q;
  logic [7:0]        flag_rise;
  logic              preq_q;
  logic              preq_d;
  logic              irq_q;
  logic              irq_d;

  // true when the word address hits a mapped register
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = (a == OFS_FLAGS) || (a == OFS_ICTRL) || (a == OFS_ENABLE)
             || (a == OFS_EVSTAT) || (a == OFS_EVMASK);
  endfunction

  // the low two address bits are ignored, so any byte address picks its word
  function automatic logic [AXI_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
    word_of = {a[AXI_AW-1:2], 2'h0};
  endfunction

  // write path
  // address and data may arrive in either order; both are held until the write
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    waddr_d  = waddr_q;
    wbyte_d  = wbyte_q;
    wlane_d  = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    do_wr    = aw_got_q && w_got_q;
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      waddr_d  = word_of(s_axi_awaddr);
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = is_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // no new beat while one is held or its answer waits
    awready_d = !aw_got_d && !bvalid_d && !do_wr;
    wready_d  = !w_got_d && !bvalid_d && !do_wr;
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      waddr_q   <= waddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // read path
  // data is looked up one cycle after the address is taken
  always_comb begin
    ar_got_d = ar_got_q;
    raddr_d  = raddr_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    do_rd    = ar_got_q;
    if (s_axi_arvalid && arready_q) begin
      ar_got_d = 1'b1;
      raddr_d  = word_of(s_axi_araddr);
    end
    if (do_rd) begin
      ar_got_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d  = is_mapped(raddr_q) ? RESP_OKAY : RESP_SLVERR;
      unique case (raddr_q)
        OFS_FLAGS:  rdata_d = fl.flags;
        OFS_ICTRL:  rdata_d = ictrl_q;
        OFS_ENABLE: rdata_d = enable_q;
        OFS_EVSTAT: rdata_d = evstat_q;
        OFS_EVMASK: rdata_d = evmask_q;
        default:    rdata_d = 8'h00;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !ar_got_d && !rvalid_d && !do_rd;
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_got_q  <= 1'b0;
      raddr_q   <= '0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 8'h00;
      rresp_q   <= RESP_OKAY;
    end else begin
      ar_got_q  <= ar_got_d;
      raddr_q   <= raddr_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // flag bank
  // event pulses feed straight in; they come from logic on this clock
  always_comb begin
    fl.set_pulse                = 8'h00;
    fl.set_pulse[BIT_T1_GATE]   = timer_one_gate_evt;
    fl.set_pulse[BIT_ADC]       = converter_done_evt;
    fl.set_pulse[BIT_SSP]       = sync_serial_evt;
    fl.set_pulse[BIT_CCP1]      = capcomp_one_evt;
    fl.set_pulse[BIT_T2_MATCH]  = timer_two_match_evt;
    fl.set_pulse[BIT_T1_OVF]    = timer_one_overflow_evt;
    fl.rx_level                 = uart_rx_pending;
    fl.tx_level                 = uart_tx_pending;
    fl.sw_we    = do_wr && wlane_q && (waddr_q == OFS_FLAGS);
    fl.sw_wdata = wbyte_q;
  end

  pirqf_flag_bank u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fl      (fl.bank)
  );

  // control registers
  // only byte lane zero carries register bits; other lanes are dropped
  always_comb begin
    ictrl_d  = ictrl_q;
    enable_d = enable_q;
    evmask_d = evmask_q;
    if (do_wr && wlane_q) begin
      unique case (waddr_q)
        OFS_ICTRL:  ictrl_d  = wbyte_q & ((8'h01 << BIT_GLOB_EN) | (8'h01 << BIT_PERIPH_EN));
        OFS_ENABLE: enable_d = wbyte_q;
        OFS_EVMASK: evmask_d = wbyte_q;
        default:    ictrl_d  = ictrl_q;
      endcase
    end
  end

  // control registers; enables never touch the flags themselves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ictrl_q  <= ICTRL_RST;
      enable_q <= EN_RST;
      evmask_q <= EV_RST;
    end else begin
      ictrl_q  <= ictrl_d;
      enable_q <= enable_d;
      evmask_q <= evmask_d;
    end
  end

  // event status and interrupt outputs
  // a flag rising is an event; a read of the status clears it
  assign flag_rise = fl.flags & ~flags_prev_q;

  // set wins over the read clear so a rising flag is never lost
  always_comb begin
    evstat_d = evstat_q;
    if (do_rd && (raddr_q == OFS_EVSTAT)) begin
      evstat_d = 8'h00;
    end
    evstat_d = evstat_d | flag_rise;
    // requests to the processor wait for the peripheral enable
    preq_d = ictrl_q[BIT_PERIPH_EN] && |(fl.flags & enable_q);
    irq_d  = ictrl_q[BIT_PERIPH_EN] && |(evstat_q & evmask_q);
  end

  // status and output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evstat_q     <= EV_RST;
      flags_prev_q <= FLAGS_RST;
      preq_q       <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      evstat_q     <= evstat_d;
      flags_prev_q <= fl.flags;
      preq_q       <= preq_d;
      irq_q        <= irq_d;
    end
  end

  // outputs, all straight from flip-flops
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rresp       = rresp_q;
  assign s_axi_rdata       = {24'h000000, rdata_q};
  assign periph_irq_req    = preq_q;
  assign global_irq_enable = ictrl_q[BIT_GLOB_EN];
  assign irq               = irq_q;
endmodule
